// file: verilog/fmx_pkg.sv
// package for the fan mux and power-up fail-safe block
package fmx_pkg;

  // register offsets
  localparam logic [7:0] FMX_OFS_DUTY1 = 8'h30;
  localparam logic [7:0] FMX_OFS_DUTY2 = 8'h31;
  localparam logic [7:0] FMX_OFS_DUTY3 = 8'h32;
  localparam logic [7:0] FMX_OFS_CFG1  = 8'h5c;
  localparam logic [7:0] FMX_OFS_CFG2  = 8'h5d;
  localparam logic [7:0] FMX_OFS_CFG3  = 8'h5e;
  localparam logic [7:0] FMX_OFS_TCAL0 = 8'h67;
  localparam logic [7:0] FMX_OFS_PMIN0 = 8'h64;
  localparam logic [7:0] FMX_OFS_PINS  = 8'h7e;

  // field positions
  localparam int FMX_FAN_BEHAVIOUR_SELECT_LSB = 5;
  localparam int FMX_FAN_BEHAVIOUR_SELECT_MSB = 7;
  localparam int FMX_PIN_FOURTH_TACH_INPUT_BIT = 0;
  localparam int FMX_PIN_PWM2_BIT  = 1;

  // reset values and full/off duty levels
  localparam logic [7:0] FMX_DUTY_RST = 8'hff;
  localparam logic [7:0] FMX_CFG_RST_BASE = 8'h82;
  localparam logic [7:0] FMX_CFG_RST_ALT  = 8'h62;
  localparam logic [7:0] FMX_FAN_START_TEMPERATURE_RST = 8'h9a;
  localparam logic [7:0] FMX_PMIN_RST = 8'h80;
  localparam logic [7:0] FMX_PINS_RST = 8'h00;
  localparam logic [7:0] FMX_DUTY_FULL = 8'hff;
  localparam logic [7:0] FMX_DUTY_OFF  = 8'h00;
  localparam logic [7:0] FMX_SPAN_RST = 8'h20;

  // fail-safe time
  localparam longint FMX_CLK_HZ = 10000000;
  localparam longint FMX_FAILSAFE_MS = 4600;
  localparam longint FMX_FAILSAFE_CYC = FMX_FAILSAFE_MS * FMX_CLK_HZ / 1000;

  typedef enum logic [2:0] {
    FMX_BH_REMOTE1 = 3'b000,
    FMX_BH_LOCAL   = 3'b001,
    FMX_BH_REMOTE2 = 3'b010,
    FMX_BH_FULL    = 3'b011,
    FMX_BH_OFF     = 3'b100,
    FMX_BH_LOC_R2  = 3'b101,
    FMX_BH_ALL3    = 3'b110,
    FMX_BH_MANUAL  = 3'b111
  } fmx_fan_behaviour_select_type;

  typedef enum logic [1:0] {
    FMX_PS_WAIT_SUPPLY = 2'b00,
    FMX_PS_COUNTING    = 2'b01,
    FMX_PS_FORCED_FULL = 2'b10,
    FMX_PS_NORMAL      = 2'b11
  } fmx_pstate_type;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } fmx_wr_type;

  typedef struct packed {
    logic [7:0] fan_start_temperature;
    logic [7:0] span;
  } fmx_tcal_type;

endpackage

// file: verilog/fmx_thermal_cal.sv
// per-channel thermal calibration: temperature to speed request
`timescale 1ns/1ps
`default_nettype none
module fmx_thermal_cal
  import fmx_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  // calibration and temperature
  input  wire fmx_tcal_type     cal_in,
  input  wire logic [WIDTH-1:0] temp_in,
  // speed request
  output logic      [WIDTH-1:0] request_out
);
  initial
  begin
    if (WIDTH != 8)
      $error("fmx_thermal_cal supports 8-bit data only");
  end

  logic [WIDTH-1:0] over;
  logic [15:0]      scaled;
  logic [WIDTH-1:0] request_nxt;

  // linear ramp from start temperature over the span, saturating at full
  always_comb
  begin
    over = (temp_in > cal_in.fan_start_temperature) ? WIDTH'(temp_in - cal_in.fan_start_temperature) : '0;
    scaled = (cal_in.span == '0) ? 16'hffff : 16'((over * 16'd255) / cal_in.span);
    request_nxt = (temp_in <= cal_in.fan_start_temperature) ? '0 :
                  (scaled > 16'd255) ? 8'hff : scaled[7:0];
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      request_out <= '0;
    else
      request_out <= request_nxt;
  end
endmodule
`default_nettype wire

// file: verilog/fmx_fan_shaper.sv
// per-output minimum clamp and ramp-rate limit of duty
`timescale 1ns/1ps
`default_nettype none
module fmx_fan_shaper
  import fmx_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int STEP  = 1
)
(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  // target and settings
  input  wire logic [WIDTH-1:0] target_in,
  input  wire logic [WIDTH-1:0] min_duty_in,
  input  wire logic             bypass_in,
  // applied duty
  output logic      [WIDTH-1:0] duty_out
);
  initial
  begin
    if (STEP < 1 || STEP > 255)
      $error("fmx_fan_shaper step out of range");
  end

  localparam logic [WIDTH-1:0] STEP_W = WIDTH'(STEP);
  logic [WIDTH-1:0] goal;
  logic [WIDTH-1:0] duty_nxt;

  always_comb
  begin
    // zero request stays off; otherwise never below the minimum unless bypass_in is set
    goal = (target_in != '0 && target_in < min_duty_in) ? min_duty_in : target_in;
    if (bypass_in)
      duty_nxt = target_in;
    else if (goal > duty_out)
      duty_nxt = (goal - duty_out > STEP_W) ? WIDTH'(duty_out + STEP_W) : goal;
    else if (goal < duty_out)
      duty_nxt = (duty_out - goal > STEP_W) ? WIDTH'(duty_out - STEP_W) : goal;
    else
      duty_nxt = duty_out;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      duty_out <= '0;
    else
      duty_out <= duty_nxt;
  end
endmodule
`default_nettype wire

// file: verilog/fmx_fan_mux.sv
// fan behaviour mux with power-up fail-safe timer and register file
// Notes on behaviour
// [RULE_01] base variant samples core-supply sense at power-up
// [RULE_02] alternate variant starts with fans running
// [RULE_03] supply low: defaults once validly addressed
// [RULE_04] supply up: timeout forces full speed
// [RULE_05] late address: stop fans, load defaults
// [RULE_06] early address: normal, never forced full
// [RULE_07] behaviour field in config bits seven-five
// [RULE_08] codes 000,001,010 route single channels
// [RULE_09] code 101: max of local, remote2
// [RULE_10] code 110: max of all three
// [RULE_11] per-channel request, maximum drives output
// [RULE_12] three sources, three outputs, four tachs
// [RULE_13] calibration held per temperature channel
// [RULE_14] per-output minimum duty and ramp control
// [RULE_15] automatic control runs without host traffic
// [RULE_16] pin functions selectable by software
// [RULE_17] codes 011 full, 100 off, 111 manual
// [RULE_18] manual mode applies written duty register
// [RULE_19] fail-safe counted in clocks; valid means address ack
`timescale 1ns/1ps
`default_nettype none
module fmx_fan_mux
  import fmx_pkg::*;
#(
  parameter longint FAILSAFE_CYC = FMX_FAILSAFE_CYC,
  parameter bit     ALT_VARIANT  = 1'b0,
  parameter int     RAMP_STEP    = 1
)
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // supply sense comparator, high above threshold
  input  wire logic        cpu_core_supply_sense_in,
  // serial-bus engine side
  input  wire logic        addr_ack_in,
  input  wire fmx_wr_type  reg_wr_in,
  input  wire logic [7:0]  reg_rd_addr_in,
  output logic      [7:0]  reg_rd_data_out,
  // measured temperatures: remote1, local, remote2
  input  wire logic [7:0]  temp_remote1_in,
  input  wire logic [7:0]  temp_local_in,
  input  wire logic [7:0]  temp_remote2_in,
  // fan drive duties
  output logic [2:0][7:0]  fan_drive_output_out,
  // pin function selects and status
  output logic             fourth_tach_select_out,
  output logic             pwm2_select_out,
  output logic             forced_full_out
);
  initial
  begin
    if (FAILSAFE_CYC < 1)
      $error("fmx_fan_mux fail-safe count must be positive");
  end

  localparam logic [7:0] CFG_RST = ALT_VARIANT ? FMX_CFG_RST_ALT : FMX_CFG_RST_BASE;
  localparam logic [31:0] FS_LAST = 32'(FAILSAFE_CYC - 1);

  fmx_pstate_type  pstate_r;
  logic [31:0]     fs_count_r;
  logic [2:0][7:0] cfg_r;
  logic [2:0][7:0] duty_reg_r;
  logic [2:0][7:0] pmin_r;
  fmx_tcal_type [2:0] tcal_r;
  logic [7:0]      pins_r;
  logic            load_defaults;
  logic [2:0][7:0] request;
  logic [2:0][7:0] shaped;
  logic [2:0][7:0] target;
  logic [2:0]      bypass;
  logic [2:0][7:0] temps;

  assign temps = {temp_remote2_in, temp_local_in, temp_remote1_in};

  // power-up sequencing; alternate variant skips supply polling
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      pstate_r <= ALT_VARIANT ? FMX_PS_NORMAL : FMX_PS_WAIT_SUPPLY; // [RULE_02]
    else
      case (pstate_r)
        FMX_PS_WAIT_SUPPLY:
          if (addr_ack_in)
            pstate_r <= FMX_PS_NORMAL; // [RULE_03]
          else if (cpu_core_supply_sense_in)
            pstate_r <= FMX_PS_COUNTING; // [RULE_01]
        FMX_PS_COUNTING:
          if (addr_ack_in)
            pstate_r <= FMX_PS_NORMAL; // [RULE_06]
          else if (fs_count_r == FS_LAST)
            pstate_r <= FMX_PS_FORCED_FULL; // [RULE_04]
        FMX_PS_FORCED_FULL:
          if (addr_ack_in)
            pstate_r <= FMX_PS_NORMAL; // [RULE_05]
        FMX_PS_NORMAL:
          pstate_r <= FMX_PS_NORMAL;
        default:
          pstate_r <= FMX_PS_WAIT_SUPPLY;
      endcase
  end

  // fail-safe counter in clock cycles
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      fs_count_r <= '0;
    else if (pstate_r == FMX_PS_COUNTING && fs_count_r != FS_LAST)
      fs_count_r <= fs_count_r + 32'd1; // [RULE_19]
  end

  // leaving the forced state reloads every default
  assign load_defaults = (pstate_r == FMX_PS_FORCED_FULL) && addr_ack_in; // [RULE_05]

  // register file; writes land in every power-up state, whether or not the host has been recognised, except one in the cycle whose ack leaves the forced state
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cfg_r      <= {3{CFG_RST}};
      duty_reg_r <= {3{FMX_DUTY_RST}};
      pmin_r     <= {3{FMX_PMIN_RST}};
      tcal_r     <= {3{FMX_FAN_START_TEMPERATURE_RST, FMX_SPAN_RST}};
      pins_r     <= FMX_PINS_RST;
    end
    else if (load_defaults)
    begin
      cfg_r      <= {3{CFG_RST}};
      duty_reg_r <= {3{FMX_DUTY_RST}};
      pmin_r     <= {3{FMX_PMIN_RST}};
      tcal_r     <= {3{FMX_FAN_START_TEMPERATURE_RST, FMX_SPAN_RST}};
      pins_r     <= FMX_PINS_RST;
    end
    else if (reg_wr_in.wr)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (reg_wr_in.addr == FMX_OFS_CFG1 + 8'(i))
          cfg_r[i] <= reg_wr_in.data; // [RULE_07]
        if (reg_wr_in.addr == FMX_OFS_DUTY1 + 8'(i) &&
            fmx_fan_behaviour_select_type'(cfg_r[i][FMX_FAN_BEHAVIOUR_SELECT_MSB:FMX_FAN_BEHAVIOUR_SELECT_LSB]) == FMX_BH_MANUAL)
          duty_reg_r[i] <= reg_wr_in.data; // [RULE_18]
        if (reg_wr_in.addr == FMX_OFS_PMIN0 + 8'(i))
          pmin_r[i] <= reg_wr_in.data; // [RULE_14]
        if (reg_wr_in.addr == FMX_OFS_TCAL0 + 8'(i))
          tcal_r[i].fan_start_temperature <= reg_wr_in.data; // [RULE_13]
        if (reg_wr_in.addr == FMX_OFS_TCAL0 + 8'h03 + 8'(i))
          tcal_r[i].span <= reg_wr_in.data; // [RULE_13]
      end
      if (reg_wr_in.addr == FMX_OFS_PINS)
        pins_r <= reg_wr_in.data; // [RULE_16]
    end
  end

  // one calibration block per temperature channel
  for (genvar c = 0; c < 3; c++)
  begin : g_cal
    fmx_thermal_cal #(.WIDTH(8)) u_cal (
      .clk_in      (clk_in),
      .reset_n_in  (reset_n_in),
      .cal_in      (tcal_r[c]),
      .temp_in     (temps[c]),
      .request_out (request[c])
    ); // [RULE_11] [RULE_15]
  end

  function automatic logic [7:0] fmx_max2(input logic [7:0] a, input logic [7:0] b);
    fmx_max2 = (a > b) ? a : b;
  endfunction

  // behaviour mux per output
  always_comb
  begin
    for (int o = 0; o < 3; o++)
    begin
      bypass[o] = 1'b1;
      case (fmx_fan_behaviour_select_type'(cfg_r[o][FMX_FAN_BEHAVIOUR_SELECT_MSB:FMX_FAN_BEHAVIOUR_SELECT_LSB]))
        FMX_BH_REMOTE1:
        begin
          target[o] = request[0]; // [RULE_08]
          bypass[o] = 1'b0;
        end
        FMX_BH_LOCAL:
        begin
          target[o] = request[1]; // [RULE_08]
          bypass[o] = 1'b0;
        end
        FMX_BH_REMOTE2:
        begin
          target[o] = request[2]; // [RULE_08]
          bypass[o] = 1'b0;
        end
        FMX_BH_LOC_R2:
        begin
          target[o] = fmx_max2(request[1], request[2]); // [RULE_09]
          bypass[o] = 1'b0;
        end
        FMX_BH_ALL3:
        begin
          target[o] = fmx_max2(fmx_max2(request[0], request[1]), request[2]); // [RULE_10]
          bypass[o] = 1'b0;
        end
        FMX_BH_FULL:    target[o] = FMX_DUTY_FULL; // [RULE_17]
        FMX_BH_OFF:     target[o] = FMX_DUTY_OFF; // [RULE_17]
        FMX_BH_MANUAL:  target[o] = duty_reg_r[o]; // [RULE_17]
        default:        target[o] = FMX_DUTY_OFF;
      endcase
    end
  end

  // per-output minimum and ramp
  for (genvar o = 0; o < 3; o++)
  begin : g_out
    fmx_fan_shaper #(.WIDTH(8), .STEP(RAMP_STEP)) u_shape (
      .clk_in      (clk_in),
      .reset_n_in  (reset_n_in),
      .target_in   (target[o]),
      .min_duty_in (pmin_r[o]),
      .bypass_in   (bypass[o]),
      .duty_out    (shaped[o])
    ); // [RULE_14] [RULE_12]
  end

  // forced full overrides every behaviour; cleared only by a valid address
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      fan_drive_output_out <= '0;
    else
      for (int o = 0; o < 3; o++)
        fan_drive_output_out[o] <= (pstate_r == FMX_PS_FORCED_FULL) ?
                                   FMX_DUTY_FULL : shaped[o]; // [RULE_04]
  end

  assign forced_full_out        = (pstate_r == FMX_PS_FORCED_FULL);
  assign fourth_tach_select_out = ~pins_r[FMX_PIN_FOURTH_TACH_INPUT_BIT]; // [RULE_16]
  assign pwm2_select_out        = ~pins_r[FMX_PIN_PWM2_BIT]; // [RULE_16]

  // read back; duty registers show the applied duty
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      reg_rd_data_out <= '0;
    else
    begin
      reg_rd_data_out <= '0;
      for (int i = 0; i < 3; i++)
      begin
        if (reg_rd_addr_in == FMX_OFS_CFG1 + 8'(i))
          reg_rd_data_out <= cfg_r[i];
        if (reg_rd_addr_in == FMX_OFS_DUTY1 + 8'(i))
          reg_rd_data_out <= fan_drive_output_out[i];
        if (reg_rd_addr_in == FMX_OFS_PMIN0 + 8'(i))
          reg_rd_data_out <= pmin_r[i];
        if (reg_rd_addr_in == FMX_OFS_TCAL0 + 8'(i))
          reg_rd_data_out <= tcal_r[i].fan_start_temperature;
        if (reg_rd_addr_in == FMX_OFS_TCAL0 + 8'h03 + 8'(i))
          reg_rd_data_out <= tcal_r[i].span;
      end
      if (reg_rd_addr_in == FMX_OFS_PINS)
        reg_rd_data_out <= pins_r;
    end
  end

  property p_timeout_forces;
    @(posedge clk_in) disable iff (!reset_n_in)
    (pstate_r == FMX_PS_COUNTING && fs_count_r == FS_LAST && !addr_ack_in)
      |=> forced_full_out ##1 (fan_drive_output_out == {3{FMX_DUTY_FULL}});
  endproperty
  a_timeout_forces: assert property (p_timeout_forces) else $error("timeout did not force full"); // [RULE_04]

  property p_ack_leaves_forced;
    @(posedge clk_in) disable iff (!reset_n_in)
    (forced_full_out && addr_ack_in) |=> !forced_full_out && cfg_r[0] == CFG_RST;
  endproperty
  a_ack_leaves_forced: assert property (p_ack_leaves_forced) else $error("ack kept forced state"); // [RULE_05]

  property p_early_ack_normal;
    @(posedge clk_in) disable iff (!reset_n_in)
    (pstate_r == FMX_PS_COUNTING && addr_ack_in) |=> pstate_r == FMX_PS_NORMAL ##1 !forced_full_out;
  endproperty
  a_early_ack_normal: assert property (p_early_ack_normal) else $error("early ack not normal"); // [RULE_06]

  property p_normal_stays;
    @(posedge clk_in) disable iff (!reset_n_in)
    (pstate_r == FMX_PS_NORMAL) |=> !forced_full_out;
  endproperty
  a_normal_stays: assert property (p_normal_stays) else $error("forced after normal"); // [RULE_06]

  property p_supply_starts;
    @(posedge clk_in) disable iff (!reset_n_in)
    (pstate_r == FMX_PS_WAIT_SUPPLY && cpu_core_supply_sense_in && !addr_ack_in)
      |=> pstate_r == FMX_PS_COUNTING && fs_count_r == $past(fs_count_r);
  endproperty
  a_supply_starts: assert property (p_supply_starts) else $error("supply did not start timer"); // [RULE_01]

  property p_low_ack;
    @(posedge clk_in) disable iff (!reset_n_in)
    (pstate_r == FMX_PS_WAIT_SUPPLY && addr_ack_in) |=> pstate_r == FMX_PS_NORMAL;
  endproperty
  a_low_ack: assert property (p_low_ack) else $error("low-supply ack ignored"); // [RULE_03]

  // code must have stood two cycles: shaper and output register add latency
  property p_full_code;
    @(posedge clk_in) disable iff (!reset_n_in)
    (cfg_r[1][7:5] == 3'b011 && !forced_full_out) ##1 (cfg_r[1][7:5] == 3'b011)
      |=> fan_drive_output_out[1] == FMX_DUTY_FULL;
  endproperty
  a_full_code: assert property (p_full_code) else $error("code 011 not full"); // [RULE_17]

  property p_manual_drive;
    @(posedge clk_in) disable iff (!reset_n_in)
    (cfg_r[0][7:5] == 3'b111 && $past(cfg_r[0][7:5]) == 3'b111 && !forced_full_out
     && $stable(duty_reg_r[0]))
      |=> fan_drive_output_out[0] == $past(duty_reg_r[0]);
  endproperty
  a_manual_drive: assert property (p_manual_drive) else $error("manual duty not applied"); // [RULE_18]

  property p_max_all3;
    @(posedge clk_in) disable iff (!reset_n_in)
    (cfg_r[2][7:5] == 3'b110) |-> target[2] >= request[0] && target[2] >= request[1]
                                  && target[2] >= request[2]
                                  && (target[2] == request[0] || target[2] == request[1]
                                      || target[2] == request[2]);
  endproperty
  a_max_all3: assert property (p_max_all3) else $error("code 110 not maximum"); // [RULE_10]
endmodule
`default_nettype wire

// file: verif/fmx_host_model.sv
// management-bus host model driving the register and address-ack side
`timescale 1ns/1ps
`default_nettype none
module fmx_host_model
  import fmx_pkg::*;
(
  // clock
  input  wire logic       clk_in,
  // read data back from the device
  input  wire logic [7:0] rd_data_in,
  // requests towards the device
  output var  logic       addr_ack_out,
  output var  fmx_wr_type reg_wr_out,
  output var  logic [7:0] rd_addr_out
);
  initial
  begin
    addr_ack_out = 1'b0;
    reg_wr_out   = '0;
    rd_addr_out  = 8'h00;
  end

  // idle bus shows the inverse of the last byte, never a stale copy
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_wr_out = '{wr: 1'b1, addr: a, data: d};
    @(negedge clk_in);
    reg_wr_out = '{wr: 1'b0, addr: ~a, data: ~d};
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    rd_addr_out = a;
    @(negedge clk_in);
    d = rd_data_in;
  endtask

  // one-cycle pulse: our address was acknowledged
  task automatic address_device();
    @(negedge clk_in);
    addr_ack_out = 1'b1;
    @(negedge clk_in);
    addr_ack_out = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: verif/fmx_fan_mux_test.sv
// self-checking bench for the fan mux and power-up fail-safe
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
  $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module fmx_fan_mux_test;
  import fmx_pkg::*;
  logic            clk;
  logic            reset_n;
  logic            supply;
  logic            ack;
  fmx_wr_type      wr;
  logic [7:0]      rd_addr;
  logic [7:0]      rd_data;
  logic [7:0]      t_r1;
  logic [7:0]      t_lc;
  logic [7:0]      t_r2;
  logic [2:0][7:0] duty;
  logic            tach_sel;
  logic            pwm2_sel;
  logic            forced;
  int              failures;
  int              n_tests;
  int              n;
  logic [2:0][7:0] alt_duty;
  logic            alt_forced;
  // each code's result differs from the one before it
  logic [2:0]      codes [5] = '{3'b000, 3'b010, 3'b001, 3'b101, 3'b110};
  logic [7:0]      exps  [5] = '{8'h60, 8'h48, 8'h30, 8'h48, 8'h60};

  // short fail-safe keeps the run small
  localparam int FS_CYC = 20;

  fmx_fan_mux #(.FAILSAFE_CYC(FS_CYC), .ALT_VARIANT(1'b0), .RAMP_STEP(1)) i_fmx_fan_mux (
    .clk_in(clk), .reset_n_in(reset_n), .cpu_core_supply_sense_in(supply),
    .addr_ack_in(ack), .reg_wr_in(wr), .reg_rd_addr_in(rd_addr),
    .reg_rd_data_out(rd_data), .temp_remote1_in(t_r1), .temp_local_in(t_lc),
    .temp_remote2_in(t_r2), .fan_drive_output_out(duty),
    .fourth_tach_select_out(tach_sel), .pwm2_select_out(pwm2_sel),
    .forced_full_out(forced));

  // alternate variant shares the bus; only its start-up is judged
  fmx_fan_mux #(.FAILSAFE_CYC(FS_CYC), .ALT_VARIANT(1'b1), .RAMP_STEP(1)) i_fmx_fan_mux_alt (
    .clk_in(clk), .reset_n_in(reset_n), .cpu_core_supply_sense_in(supply),
    .addr_ack_in(ack), .reg_wr_in(wr), .reg_rd_addr_in(rd_addr),
    .reg_rd_data_out(), .temp_remote1_in(t_r1), .temp_local_in(t_lc),
    .temp_remote2_in(t_r2), .fan_drive_output_out(alt_duty),
    .fourth_tach_select_out(), .pwm2_select_out(),
    .forced_full_out(alt_forced));

  fmx_host_model i_fmx_host_model (
    .clk_in(clk), .rd_data_in(rd_data), .addr_ack_out(ack),
    .reg_wr_out(wr), .rd_addr_out(rd_addr));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    i_fmx_host_model.write_reg(a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_fmx_host_model.read_reg(a, d);
    `CHK(d, e)
  endtask

  task automatic wait_duty(input int i, input logic [7:0] e);
    int k;
    k = 0;
    while (duty[i] !== e && k < 600)
    begin
      @(negedge clk);
      k++;
    end
    // a ramp passing through the value must not count as settled
    repeat (4) @(negedge clk);
    `CHK(duty[i], e)
  endtask

  task automatic no_force(input int cycles);
    logic seen;
    seen = 1'b0;
    repeat (cycles)
    begin
      @(negedge clk);
      if (forced !== 1'b0)
        seen = 1'b1;
    end
    `CHK(seen, 1'b0)
  endtask

  task automatic do_reset(input logic s);
    @(negedge clk);
    reset_n = 1'b0;
    supply  = s;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    failures++;
    end_of_test();
  end

  initial
  begin
    failures = 0;
    n_tests  = 0;
    reset_n  = 1'b0;
    supply   = 1'b0;
    t_r1     = 8'h60;
    t_lc     = 8'h30;
    t_r2     = 8'h48;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    rd_chk(FMX_OFS_CFG1, FMX_CFG_RST_BASE);
    rd_chk(FMX_OFS_CFG2, FMX_CFG_RST_BASE);
    rd_chk(FMX_OFS_CFG3, FMX_CFG_RST_BASE);
    rd_chk(8'h70, 8'h00);
    `CHK({tach_sel, pwm2_sel}, 2'b11)
    `CHK({alt_forced, alt_duty}, {1'b0, {3{FMX_DUTY_FULL}}})
    // supply low: no timer, defaults after addressing
    no_force(40);
    i_fmx_host_model.address_device();
    supply = 1'b1;
    no_force(40);
    rd_chk(FMX_OFS_CFG1, FMX_CFG_RST_BASE);
    // supply up, nobody talks: forced full after the count
    do_reset(1'b1);
    n = 0;
    while (forced !== 1'b1 && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    `CHK((n == FS_CYC + 1), 1'b1)
    @(negedge clk);
    `CHK(duty, {3{FMX_DUTY_FULL}})
    repeat (5) @(negedge clk);
    `CHK(forced, 1'b1)
    i_fmx_host_model.address_device();
    `CHK(forced, 1'b0)
    repeat (3) @(negedge clk);
    `CHK(duty, {3{FMX_DUTY_OFF}})
    rd_chk(FMX_OFS_CFG1, FMX_CFG_RST_BASE);
    // early addressing never forces full
    do_reset(1'b1);
    repeat (5) @(negedge clk);
    i_fmx_host_model.address_device();
    no_force(40);
    // manual, full and off codes; duty writes refused outside manual
    wr_reg(FMX_OFS_CFG1, 8'he0);
    wr_reg(FMX_OFS_DUTY1, 8'h40);
    wait_duty(0, 8'h40);
    rd_chk(FMX_OFS_DUTY1, 8'h40);
    wr_reg(FMX_OFS_DUTY2, 8'h55);
    repeat (4) @(negedge clk);
    `CHK(duty[1], FMX_DUTY_OFF)
    wr_reg(FMX_OFS_CFG2, 8'he0);
    wait_duty(1, FMX_DUTY_RST);
    wr_reg(FMX_OFS_CFG2, 8'h80);
    wait_duty(1, FMX_DUTY_OFF);
    wr_reg(FMX_OFS_CFG2, 8'h60);
    wait_duty(1, FMX_DUTY_FULL);
    // calibration that makes each request equal its temperature
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(FMX_OFS_TCAL0 + 8'(i), 8'h00);
      wr_reg(8'h6a + 8'(i), 8'hff);
      wr_reg(FMX_OFS_PMIN0 + 8'(i), 8'h00);
    end
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(FMX_OFS_CFG3, {codes[i], 5'h02});
      wait_duty(2, exps[i]);
    end
    t_lc = 8'h70;
    wait_duty(2, 8'h70);
    // per-output minimum and per-channel calibration
    wr_reg(FMX_OFS_PMIN0, 8'h70);
    wr_reg(FMX_OFS_CFG1, 8'h02);
    wait_duty(0, 8'h70);
    // output three off channel one, so its span change must not reach it
    wr_reg(FMX_OFS_CFG3, {3'b101, 5'h02});
    wr_reg(8'h6a, 8'h00);
    wait_duty(0, FMX_DUTY_FULL);
    `CHK(duty[2], 8'h70)
    wr_reg(FMX_OFS_PINS, 8'h03);
    `CHK({tach_sel, pwm2_sel}, 2'b00)
    wr_reg(FMX_OFS_PINS, 8'h01);
    `CHK({tach_sel, pwm2_sel}, 2'b01)
    end_of_test();
  end
endmodule
`default_nettype wire
